// >>> bench/sem_slave_model.sv
`timescale 1ns/100ps
module sem_slave_model (
   // Clock
   input wire logic clock_i,
   // Serial pins
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic sel_i,
   output logic miso_o,
   // Mode and reply word
   input wire logic pol_i,
   input wire logic pha_i,
   input wire logic [15:0] pattern_i,
   output logic [15:0] rx_o
);
   // ****
   // Slave shifter
   // ****
   logic ps = 1'b0;
   logic pc = 1'b0;
   logic [3:0] idx = 4'hf;
   initial begin
      miso_o = 1'b0;
      rx_o = 16'h0;
   end
   // Edges seen one cycle late, so mosi is always settled here
   always @(posedge clock_i) begin
      if (!sel_i) begin
         // Released line never holds a stale bit
         miso_o <= ~miso_o;
         idx <= 4'hf;
      end else if (!pc) begin
         if (pha_i) begin
            miso_o <= pattern_i[15];
            idx <= 4'he;
         end
      end else if (sclk_i != ps) begin
         if ((sclk_i != pol_i) == pha_i) begin
            rx_o <= {rx_o[14:0], mosi_i};
         end else begin
            miso_o <= pattern_i[idx];
            idx <= idx - 4'h1;
         end
      end
      ps <= sclk_i;
      pc <= sel_i;
   end
endmodule

// >>> bench/sem_spi_master_bench.sv
`timescale 1ns/100ps
module sem_spi_master_bench;
   // ****
   // State
   // ****
   localparam int DEPTH = 4;
   typedef struct {
      int edges; int nb; int div; int lead;
      logic [15:0] rx; logic [15:0] mo; logic chk;
   } sem_exp_t;
   logic clock_i = 1'b0, rstn_i = 1'b0, tx_valid = 1'b0, srst = 1'b0;
   logic fixed = 1'b0, tx_ready, rdy_flag, t_empty, halfw, rxv, sclk, mosi;
   logic miso;
   logic [1:0] fcs = 2'h0, cur;
   logic [3:0] pol = 4'h0, pha = 4'hf, hold = 4'h0, csn;
   logic [15:0] bits = 16'h0, pat = 16'h0, rxd, srx;
   logic [31:0] tx_data = 32'h0, divs = 32'h04040404;
   int mismatches = 0, n_compared = 0, cyc = 0, edges = 0, fall = 0;
   int first = -1, last = 0, acc = 0, pdv = 4, ps = 0, mask;
   logic sp = 1'b0, cp = 1'b0;
   sem_exp_t q[$], m;

   assign cur = fixed ? fcs : tx_data[17:16];
   always #(sem_pkg::CLK_PERIOD_NS / 2) clock_i = ~clock_i;

   sem_spi_master #(.FIFO_DEPTH(DEPTH)) uut (
      .clock_i(clock_i), .rstn_i(rstn_i), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready), .tx_data_i(tx_data),
      .soft_reset_command_i(srst), .fixed_mode_i(fixed), .fixed_cs_i(fcs),
      .clock_divider_field_i(divs), .word_bits_i(bits),
      .clock_polarity_bit_i(pol), .clock_phase_bit_i(pha),
      .cs_hold_after_transfer_i(hold), .transmit_ready_flag_o(rdy_flag),
      .transmit_empty_flag_o(t_empty), .dma_halfword_o(halfw),
      .rx_data_o(rxd), .rx_valid_o(rxv), .serial_clock_pin_o(sclk),
      .mosi_o(mosi), .miso_i(miso), .cs_n_o(csn)
   );
   sem_slave_model slave (
      .clock_i(clock_i), .sclk_i(sclk), .mosi_i(mosi), .sel_i(~&csn),
      .miso_o(miso), .pol_i(pol[cur]), .pha_i(pha[cur]),
      .pattern_i(pat), .rx_o(srx)
   );
   // ****
   // Tasks
   // ****
   task automatic check(logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic sem_exp_t expect_word(int s, logic [15:0] d);
      sem_exp_t e;
      logic an;
      e.div = int'(divs[8*s +: 8]);
      e.nb = 8 + int'(bits[4*s +: 4]);
      an = (e.div % 2 == 1 && e.div != 1 && pol[s] && !pha[s])
         || (e.div == 1 && e.nb % 2 == 1)
         || (e.div == 1 && pdv != 1 && s != ps && pol[s] && !pha[s]);
      e.edges = 2 * e.nb + (an ? 2 : 0);
      e.rx = pat >> (16 - e.nb);
      e.mo = d;
      e.chk = !an && e.div >= 4;
      e.lead = -1;
      pdv = e.div;
      ps = s;
      return e;
   endfunction
   task automatic send(logic [31:0] w, sem_exp_t e, logic sr);
      int n;
      q.push_back(e);
      tx_data = w;
      tx_valid = 1'b1;
      // Ready read settled at the falling edge, before the taking edge
      for (n = 0; n < 100; n++) begin
         if (tx_ready === 1'b1) break;
         @(negedge clock_i);
      end
      @(negedge clock_i);
      tx_valid = 1'b0;
      srst = sr;
      @(negedge clock_i);
      srst = 1'b0;
      if (n == 100) begin
         mismatches++;
         results();
      end
   endtask
   task automatic wait_idle;
      int n;
      for (n = 0; n < 3000; n++) begin
         @(negedge clock_i);
         if (q.size() == 0 && t_empty === 1'b1) break;
      end
      if (n == 3000) begin
         mismatches++;
         results();
      end
   endtask
   task automatic sreset;
      @(negedge clock_i);
      srst = 1'b1;
      @(negedge clock_i);
      srst = 1'b0;
      check(csn, 4'hf);
   endtask
   // ****
   // Monitor
   // ****
   always @(negedge clock_i) begin
      cyc++;
      if (~&csn && !cp) fall = cyc;
      if (sclk !== sp && ~&csn) begin
         if (first < 0) first = cyc;
         if (cp) begin
            if (edges > 0 && q.size() > 0 && q[0].chk)
               check(cyc - last, q[0].div);
            edges++;
            last = cyc;
         end
      end
      if (rxv === 1'b1) begin
         if (q.size() == 0) check(1, 0);
         else begin
            m = q.pop_front();
            mask = (1 << m.nb) - 1;
            if (m.edges >= 0) check(edges, m.edges);
            if (m.chk) check(rxd & mask, m.rx & mask);
            if (m.chk) check(srx & mask, m.mo & mask);
            if (m.lead == 0) check(first - fall, 0);
            if (m.lead > 0) check(first > fall, 1);
         end
         edges = 0;
         first = -1;
      end
      sp = sclk;
      cp = ~&csn;
   end
   // ****
   // Sequence
   // ****
   initial begin
      sem_exp_t e;
      int s;
      logic [31:0] w;
      void'($urandom(32'h033807fb));
      repeat (2) @(negedge clock_i);
      rstn_i = 1'b1;
      check(csn, 4'hf);
      check(t_empty, 1'b1);
      check(tx_ready, 1'b1);
      // Soft reset colliding with a pop, then lone and paired resets
      pat = 16'($urandom);
      e = expect_word(0, 16'h00a5);
      e.lead = 1;
      send(32'h000000a5, e, 1'b1);
      wait_idle();
      sreset();
      e = expect_word(0, 16'h005a);
      e.lead = 0;
      e.edges = -1;
      e.chk = 1'b0;
      send(32'h0000005a, e, 1'b0);
      wait_idle();
      sreset();
      e = expect_word(0, 16'h0081);
      e.lead = 1;
      send(32'h00000081, e, 1'b0);
      wait_idle();
      // Random sweep; edge count of a batch's first word unchecked, history unknown
      for (int i = 0; i < 48; i++) begin
         if (i % 12 == 0) begin
            for (int k = 0; k < 4; k++) begin
               divs[8*k +: 8] = 8'($urandom_range(5, 1));
               bits[4*k +: 4] = 4'($urandom_range(8, 0));
            end
            pha = 4'($urandom);
            pol = (i < 12) ? 4'h0 : 4'hf;
            if (i == 12) begin
               divs = 32'h05020103;
               pha = 4'h0;
            end
            if (i == 36) divs = 32'h01010101;
         end
         s = $urandom_range(3, 0);
         pat = 16'($urandom);
         w = {14'h0, 2'(s), 16'($urandom)};
         e = expect_word(s, w[15:0]);
         if (i % 12 == 0) e.edges = -1;
         send(w, e, 1'b0);
         wait_idle();
      end
      fixed = 1'b1;
      fcs = 2'h1;
      for (int b = 0; b < 9; b++) begin
         bits = {12'h0, 4'(b)};
         @(negedge clock_i);
         check(halfw, b != 0);
      end
      fcs = 2'h2;
      hold = 4'h4;
      divs = 32'h02020202;
      pol = 4'h0;
      pha = 4'hf;
      bits = 16'h0;
      e = expect_word(2, 16'h003c);
      e.chk = 1'b0;
      send(32'h0000003c, e, 1'b0);
      wait_idle();
      check(csn, 4'hb);
      send(32'h010000c3, e, 1'b0);
      wait_idle();
      check(csn, 4'hf);
      // Held select at full rate: second and third words each go out twice
      fixed = 1'b0;
      hold = 4'h2;
      divs = 32'h01010101;
      e = expect_word(1, 16'h0011);
      e.chk = 1'b0;
      send(32'h00010011, e, 1'b0);
      wait_idle();
      repeat (3) @(negedge clock_i);
      send(32'h00010022, e, 1'b0);
      q.push_back(e);
      wait_idle();
      check(csn, 4'hd);
      send(32'h01010033, e, 1'b0);
      q.push_back(e);
      wait_idle();
      check(csn, 4'hf);
      // Fill the buffer while the shifter is busy, then drain
      hold = 4'h0;
      divs = 32'h05050505;
      pat = 16'($urandom);
      e = expect_word(0, 16'h0096);
      tx_data = 32'h00000096;
      tx_valid = 1'b1;
      for (int n = 0; n < 50; n++) begin
         if (tx_ready !== 1'b1) break;
         acc++;
         q.push_back(e);
         @(negedge clock_i);
      end
      tx_valid = 1'b0;
      check(acc, DEPTH + 1);
      check(rdy_flag, 1'b0);
      check(t_empty, 1'b0);
      wait_idle();
      check(t_empty, 1'b1);
      results();
   end
endmodule

// >>> verilog/sem_fifo.sv
`timescale 1ns/100ps
module sem_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic flush_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   assign in_ready_o = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // ****************************************
   // Pointers
   // ****************************************
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (flush_i) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
      end else begin
         if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage has no reset; empty flag guards reads
   always_ff @(posedge clock_i) begin
      if (push && !flush_i) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule

// >>> verilog/sem_pkg.sv
package sem_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 50;
   // ****************************************
   // Layout of a transmit word
   // ****************************************
   localparam int WORD_W = 32;
   localparam int DATA_W = 16;
   localparam int PCS_LSB = 16;
   localparam int LAST_BIT_POS = 24;
   // ****************************************
   // Per-select configuration
   // ****************************************
   localparam int CS_COUNT = 4;
   localparam int CS_IDX_W = 2;
   localparam int DIV_W = 8;
   localparam int BITS_W = 4;
   localparam logic [4:0] BASE_BITS = 5'h08;
   localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
   localparam logic [5:0] EXTRA_EDGES = 6'h02;
   localparam int FIFO_DEPTH_DEF = 16;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [CS_COUNT-1:0] CS_N_RST = 4'hf;
   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_LOAD = 2'b01,
      S_SHIFT = 2'b10,
      S_DONE = 2'b11
   } sem_state_t;
endpackage

// >>> verilog/sem_spi_master.sv
`timescale 1ns/100ps
// Summary of operation
// RULE1: With divider odd and not 1, polarity 1 and phase bit 0, one extra clock pulse is sent.
// RULE2: Hold-after-transfer, divider 1, same slave twice with idle between sends word two twice.
// RULE3: Fixed mode with hold set, a last-transfer bit releases the select once transmit is empty; code releases at word end, buffered or not.
// RULE4: In fixed mode the DMA transfer size follows the word length of select 0.
// RULE5: Software doing 8-bit DMA on another select sets select 0's length to 8 bits too.
// RULE6: Divider 1 runs the serial clock at the fastest rate the system clock allows.
// RULE7: Divider 1 with an odd word length of 9 to 15 bits sends one extra clock pulse.
// RULE8: Divider 1 with an even word length of 8 to 16 bits sends a clean clock.
// RULE9: A soft reset in the same cycle as a transmit-ready event is ignored.
// RULE10: Polarity 1, phase 0, going from a slower select to a divider-1 select adds a pulse.
// RULE11: When every select uses divider 1 no extra pulse appears across select changes.
// RULE12: A single soft reset leaves the clock starting before the select; a second one fixes it. Code asserts the select on the first clock edge itself.
// RULE13: Software should drive the select as a plain pin when DMA must hold it between words.
// RULE14: The serial clock is the system clock divided per select, with polarity and phase applied.
module sem_spi_master import sem_pkg::*; #(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Transmit words from software or DMA
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic [WORD_W-1:0] tx_data_i,
   // Control and configuration
   input wire logic soft_reset_command_i,
   input wire logic fixed_mode_i,
   input wire logic [CS_IDX_W-1:0] fixed_cs_i,
   input wire logic [CS_COUNT*DIV_W-1:0] clock_divider_field_i,
   input wire logic [CS_COUNT*BITS_W-1:0] word_bits_i,
   input wire logic [CS_COUNT-1:0] clock_polarity_bit_i,
   input wire logic [CS_COUNT-1:0] clock_phase_bit_i,
   input wire logic [CS_COUNT-1:0] cs_hold_after_transfer_i,
   // Status
   output logic transmit_ready_flag_o,
   output logic transmit_empty_flag_o,
   output logic dma_halfword_o,
   output logic [DATA_W-1:0] rx_data_o,
   output logic rx_valid_o,
   // Serial pins
   output logic serial_clock_pin_o,
   output logic mosi_o,
   input wire logic miso_i,
   output logic [CS_COUNT-1:0] cs_n_o
);
   // ****************************************
   // Declarations
   // ****************************************
   sem_state_t state, next_state;
   logic [DIV_W-1:0] cnt, next_cnt, cur_div, next_cur_div;
   logic [DIV_W-1:0] prev_div, next_prev_div;
   logic [5:0] edges, next_edges, tot, next_tot;
   logic [4:0] nbits, next_nbits;
   logic [DATA_W-1:0] shreg, next_shreg, rxreg, next_rxreg;
   logic [DATA_W-1:0] rx_data, next_rx_data;
   logic [WORD_W-1:0] word, next_word;
   logic [CS_COUNT-1:0] cs_n, next_cs_n;
   logic [CS_IDX_W-1:0] cur_cs, next_cur_cs, prev_cs, next_prev_cs;
   logic sclk, next_sclk, mosi, next_mosi, rx_valid, next_rx_valid;
   logic cur_clock_polarity_bit, next_cur_clock_polarity_bit, cur_clock_phase_bit, next_cur_clock_phase_bit;
   logic cur_hold, next_cur_hold, cur_last, next_cur_last;
   logic repeat_pend, next_repeat_pend, idle_seen, next_idle_seen;
   logic sr_half, next_sr_half;
   logic miso_m, miso_s;
   logic fifo_valid, pop, pop_req, flush, sr_take, tick;
   logic [WORD_W-1:0] fifo_data;
   logic [CS_IDX_W-1:0] sel;
   logic [DIV_W-1:0] sel_div [CS_COUNT];
   logic [4:0] sel_nbits [CS_COUNT];
   logic [4:0] w_nbits;
   logic [DIV_W-1:0] w_div;
   logic w_clock_polarity_bit, w_clock_phase_bit, w_extra;

   // ****************************************
   // Per-select field unpacking
   // ****************************************
   for (genvar g = 0; g < CS_COUNT; g++) begin : g_sel
      assign sel_div[g] = clock_divider_field_i[g*DIV_W +: DIV_W];
      assign sel_nbits[g] = BASE_BITS + {1'b0, word_bits_i[g*BITS_W +: BITS_W]};
   end

   // ****************************************
   // Transmit buffer
   // ****************************************
   sem_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .flush_i(flush),
      .in_valid_i(tx_valid_i),
      .in_ready_o(tx_ready_o),
      .in_data_i(tx_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_data)
   );

   // Second flop alone reads the first
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         miso_m <= 1'b0;
         miso_s <= 1'b0;
      end else begin
         miso_m <= miso_i;
         miso_s <= miso_m;
      end
   end

   // ****************************************
   // Word setup
   // ****************************************
   assign sel = fixed_mode_i ? fixed_cs_i : fifo_data[PCS_LSB +: CS_IDX_W];
   assign w_div = sel_div[sel];
   assign w_nbits = sel_nbits[sel];
   assign w_clock_polarity_bit = clock_polarity_bit_i[sel];
   assign w_clock_phase_bit = clock_phase_bit_i[sel];
   // Anomalous extra pulse; all-divider-1 setups never hit the third term
   assign w_extra = (w_div[0] && w_div != DIV_ONE && w_clock_polarity_bit && !w_clock_phase_bit)  // RULE1
      || (w_div == DIV_ONE && w_nbits[0])  // RULE7 RULE8
      || (w_div == DIV_ONE && prev_div != DIV_ONE && w_clock_polarity_bit
          && !w_clock_phase_bit);  // RULE10 RULE11
   // Size follows select 0 in fixed mode, not the selected one
   assign dma_halfword_o = fixed_mode_i ? (word_bits_i[BITS_W-1:0] != '0)
      : (w_nbits != BASE_BITS);  // RULE4
   // Divider 1 toggles every system clock, the fastest rate possible
   assign tick = (cur_div <= DIV_ONE) || (cnt == cur_div - DIV_ONE);  // RULE6 RULE14
   // Pop request comes from state and fifo_valid only, so no loop through sr_take
   assign pop_req = (state == S_IDLE) && fifo_valid;
   assign sr_take = soft_reset_command_i && !pop_req;  // RULE9
   assign flush = sr_take;
   assign transmit_ready_flag_o = tx_ready_o;
   assign transmit_empty_flag_o = (state == S_IDLE) && !fifo_valid;

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_cur_div = cur_div;
      next_prev_div = prev_div;
      next_edges = edges;
      next_tot = tot;
      next_nbits = nbits;
      next_shreg = shreg;
      next_rxreg = rxreg;
      next_rx_data = rx_data;
      next_word = word;
      next_cs_n = cs_n;
      next_cur_cs = cur_cs;
      next_prev_cs = prev_cs;
      next_sclk = sclk;
      next_mosi = mosi;
      next_rx_valid = 1'b0;
      next_cur_clock_polarity_bit = cur_clock_polarity_bit;
      next_cur_clock_phase_bit = cur_clock_phase_bit;
      next_cur_hold = cur_hold;
      next_cur_last = cur_last;
      next_repeat_pend = repeat_pend;
      next_idle_seen = idle_seen;
      next_sr_half = sr_half;
      pop = 1'b0;
      if (sr_take) begin
         next_state = S_IDLE;
         next_cs_n = CS_N_RST;
         next_sclk = cur_clock_polarity_bit;
         next_repeat_pend = 1'b0;
         next_sr_half = !sr_half;  // RULE12
      end else begin
         case (state)
            S_IDLE: begin
               if (!fifo_valid) begin
                  next_idle_seen = 1'b1;
               end else begin
                  pop = 1'b1;
                  next_word = fifo_data;
                  next_cur_cs = sel;
                  next_cur_div = w_div;
                  next_nbits = w_nbits;
                  next_cur_clock_polarity_bit = w_clock_polarity_bit;
                  next_cur_clock_phase_bit = w_clock_phase_bit;
                  next_cur_hold = cs_hold_after_transfer_i[sel];
                  next_cur_last = fifo_data[LAST_BIT_POS];
                  next_tot = {w_nbits, 1'b0} + (w_extra ? EXTRA_EDGES : '0);
                  next_repeat_pend = cs_hold_after_transfer_i[sel]
                     && w_div == DIV_ONE && sel == prev_cs && idle_seen
                     && !cs_n[sel];  // RULE2
                  next_idle_seen = 1'b0;
                  next_state = S_LOAD;
               end
            end
            S_LOAD: begin
               next_shreg = word[DATA_W-1:0] << (5'd16 - nbits);
               next_mosi = cur_clock_phase_bit ? next_shreg[DATA_W-1] : mosi;
               next_sclk = cur_clock_polarity_bit;
               next_cnt = '0;
               next_edges = '0;
               // Select held back to the first clock edge after one lone soft reset
               if (!sr_half) begin
                  next_cs_n = ~(4'h1 << cur_cs);
               end
               next_state = S_SHIFT;
            end
            S_SHIFT: begin
               next_cnt = tick ? '0 : cnt + DIV_ONE;
               if (tick) begin
                  next_sclk = !sclk;  // RULE14
                  next_edges = edges + 6'h01;
                  next_cs_n = ~(4'h1 << cur_cs);  // RULE12
                  if (edges[0] == cur_clock_phase_bit) begin
                     next_mosi = cur_clock_phase_bit ? shreg[DATA_W-2] : shreg[DATA_W-1];
                     next_shreg = {shreg[DATA_W-2:0], 1'b0};
                  end else begin
                     next_rxreg = {rxreg[DATA_W-2:0], miso_s};
                  end
                  if (edges + 6'h01 == tot) begin
                     next_state = S_DONE;
                  end
               end
            end
            S_DONE: begin
               next_rx_valid = 1'b1;
               next_rx_data = rxreg;
               next_prev_cs = cur_cs;
               next_prev_div = cur_div;
               next_sclk = cur_clock_polarity_bit;
               if (repeat_pend) begin
                  next_repeat_pend = 1'b0;
                  next_state = S_LOAD;  // RULE2
               end else begin
                  // Release on last-transfer bit at the end of the word, buffered words or not
                  if (cur_last || !cur_hold) begin
                     next_cs_n = CS_N_RST;  // RULE3
                  end
                  next_state = S_IDLE;
               end
            end
            default: next_state = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state <= S_IDLE;
         cnt <= '0;
         cur_div <= DIV_ONE;
         prev_div <= DIV_ONE;
         edges <= '0;
         tot <= '0;
         nbits <= BASE_BITS;
         shreg <= '0;
         rxreg <= '0;
         rx_data <= '0;
         word <= '0;
         cs_n <= CS_N_RST;
         cur_cs <= '0;
         prev_cs <= '0;
         sclk <= 1'b0;
         mosi <= 1'b0;
         rx_valid <= 1'b0;
         cur_clock_polarity_bit <= 1'b0;
         cur_clock_phase_bit <= 1'b0;
         cur_hold <= 1'b0;
         cur_last <= 1'b0;
         repeat_pend <= 1'b0;
         idle_seen <= 1'b0;
         sr_half <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cur_div <= next_cur_div;
         prev_div <= next_prev_div;
         edges <= next_edges;
         tot <= next_tot;
         nbits <= next_nbits;
         shreg <= next_shreg;
         rxreg <= next_rxreg;
         rx_data <= next_rx_data;
         word <= next_word;
         cs_n <= next_cs_n;
         cur_cs <= next_cur_cs;
         prev_cs <= next_prev_cs;
         sclk <= next_sclk;
         mosi <= next_mosi;
         rx_valid <= next_rx_valid;
         cur_clock_polarity_bit <= next_cur_clock_polarity_bit;
         cur_clock_phase_bit <= next_cur_clock_phase_bit;
         cur_hold <= next_cur_hold;
         cur_last <= next_cur_last;
         repeat_pend <= next_repeat_pend;
         idle_seen <= next_idle_seen;
         sr_half <= next_sr_half;
      end
   end

   assign serial_clock_pin_o = sclk;
   assign mosi_o = mosi;
   assign cs_n_o = cs_n;
   assign rx_data_o = rx_data;
   assign rx_valid_o = rx_valid;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   AST_ODD_DIV_PULSE: assert property ( // RULE1
      state == S_SHIFT && cur_div[0] && cur_div != DIV_ONE && cur_clock_polarity_bit
      && !cur_clock_phase_bit |-> tot == {nbits, 1'b0} + EXTRA_EDGES)
      else $error("odd divider pulse missing");
   AST_DOUBLE_SEND: assert property ( // RULE2
      state == S_DONE && repeat_pend && !sr_take |=> state == S_LOAD
      ##1 state == S_SHIFT)
      else $error("repeated word not resent");
   AST_LAST_RELEASE: assert property ( // RULE3
      state == S_DONE && !repeat_pend && cur_last && !sr_take
      |=> cs_n == CS_N_RST && state == S_IDLE)
      else $error("select held after last transfer");
   AST_DMA_SIZE: assert property ( // RULE4
      fixed_mode_i |-> dma_halfword_o == (word_bits_i[BITS_W-1:0] != '0))
      else $error("dma size not from select 0");
   AST_FULL_RATE: assert property ( // RULE6
      state == S_SHIFT && $past(state) == S_SHIFT && cur_div == DIV_ONE
      |-> sclk != $past(sclk))
      else $error("divider 1 clock not toggling each cycle");
   AST_ODD_LEN_PULSE: assert property ( // RULE7
      state == S_SHIFT && cur_div == DIV_ONE && nbits[0]
      |-> tot == {nbits, 1'b0} + EXTRA_EDGES)
      else $error("odd length pulse missing");
   AST_EVEN_CLEAN: assert property ( // RULE8
      state == S_SHIFT && cur_div == DIV_ONE && !nbits[0]
      && (prev_div == DIV_ONE || !cur_clock_polarity_bit || cur_clock_phase_bit)
      |-> tot == {nbits, 1'b0})
      else $error("even length clock not clean");
   AST_RESET_LOST: assert property ( // RULE9
      soft_reset_command_i && pop |=> sr_half == $past(sr_half))
      else $error("soft reset acted during transmit-ready event");
   AST_SWITCH_PULSE: assert property ( // RULE10
      state == S_SHIFT && cur_div == DIV_ONE && prev_div != DIV_ONE
      && cur_clock_polarity_bit && !cur_clock_phase_bit |-> tot == {nbits, 1'b0} + EXTRA_EDGES)
      else $error("select switch pulse missing");
   AST_TWICE: assert property ( // RULE12
      sr_take |=> sr_half != $past(sr_half) && state == S_IDLE)
      else $error("soft reset did not advance");
endmodule
